// file: hdl/mcc_cmd.v
// misc settings and cold junction compensation command interpreter
`include "mcc_defs.vh"

module mcc_cmd
(
  input  wire        mclk,
  input  wire        srst,
  input  wire [7:0]  rx_data,
  input  wire        rx_valid,
  input  wire        rx_end,
  output wire [7:0]  tx_data,
  output wire        tx_valid,
  output wire        tx_last,
  input  wire        tx_ready,
  output reg  [7:0]  misc_settings,
  output wire        filter_50hz,
  output wire        fast_mode,
  output reg  [15:0] cold_junction_comp_offset,
  output reg         cold_junction_comp_enable,
  input  wire [3:0]  wb_adr_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  input  wire [3:0]  wb_sel_i,
  input  wire        wb_we_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  output reg         wb_ack_o,
  output wire        irq
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_RX   = 3'b001;
  localparam ST_EVAL = 3'b010;
  localparam ST_TX   = 3'b100;

  reg [2:0]  state;
  reg [2:0]  cnt;
  reg [7:0]  b0;
  reg [7:0]  b1;
  reg [7:0]  b2;
  reg [7:0]  b3;
  reg [7:0]  b4;
  reg [7:0]  b5;
  reg [39:0] shift;
  reg [2:0]  left;
  reg [7:0]  own_addr;
  reg        cap_filter;
  reg        cap_fast;
  reg        cap_tc;
  reg [3:0]  irq_stat;
  reg [3:0]  irq_mask;

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  reg        hdr_ok;
  reg        known;
  reg        bad;
  reg [7:0]  res_mask;
  reg [15:0] ofs_in;
  reg        ofs_ok;
  reg [2:0]  rlen;
  reg [39:0] rbuf;
  reg [3:0]  ev;

  always @*
  begin
    ofs_in   = {b4, b5};
    // a signed compare keeps -0x1000 legal and rejects -0x1001
    ofs_ok   = ($signed(ofs_in) <= $signed(`MCC_OFS_MAX)) &&
               ($signed(ofs_in) >= $signed(`MCC_OFS_MIN));
    res_mask = `MCC_RES_FIXED;
    if (!cap_filter)
      res_mask[`MCC_BIT_FILTER] = 1'b1;
    if (!cap_fast)
      res_mask[`MCC_BIT_FAST] = 1'b1;
    hdr_ok = (cnt >= 3'h3) && (b0 == own_addr) && (b1 == `MCC_FN_USER) &&
             (own_addr >= `MCC_ADDR_MIN) && (own_addr <= `MCC_ADDR_MAX);
    known  = 1'b0;
    bad    = 1'b0;
    rlen   = `MCC_LEN_MISC_WR;
    rbuf   = {b0, `MCC_FN_USER, b2, `MCC_STATUS_OK, 8'h00};
    ev     = 4'h0;
    case (b2)
      `MCC_SUB_MISC_WR:
      begin
        known = 1'b1;
        bad   = (cnt != `MCC_LEN_MISC_WR) || ((b3 & res_mask) != 8'h00);
        ev[`MCC_IRQ_MISC] = 1'b1;
      end
      `MCC_SUB_OFS_RD:
      begin
        known = cap_tc;
        bad   = (cnt != `MCC_LEN_OFS_RD) || (b3 != 8'h00);
        rlen  = 3'h5;
        rbuf  = {b0, `MCC_FN_USER, b2, cold_junction_comp_offset[15:8],
                 cold_junction_comp_offset[7:0]};
      end
      `MCC_SUB_OFS_WR:
      begin
        known = cap_tc;
        bad   = (cnt != `MCC_LEN_OFS_WR) || (b3 != 8'h00) || !ofs_ok;
        ev[`MCC_IRQ_OFS] = 1'b1;
      end
      `MCC_SUB_EN_RD:
      begin
        known = cap_tc;
        bad   = (cnt != `MCC_LEN_EN_RD);
        rbuf  = {b0, `MCC_FN_USER, b2, 7'h00, cold_junction_comp_enable, 8'h00};
      end
      `MCC_SUB_EN_WR:
      begin
        known = cap_tc;
        bad   = (cnt != `MCC_LEN_EN_WR) || (b3 != 8'h00) || (b4 > 8'h01);
        ev[`MCC_IRQ_EN] = 1'b1;
      end
      default:
      begin
        known = 1'b0;
      end
    endcase
    if (bad)
    begin
      rlen = `MCC_LEN_EXC;
      rbuf = {b0, `MCC_FN_EXCEPT, `MCC_EXC_CODE, 16'h0000};
      ev   = 4'h0;
      ev[`MCC_IRQ_EXC] = 1'b1;
    end
  end

  wire take = hdr_ok && known;

  // ----------------------------------------
  // frame capture, evaluation and reply
  // ----------------------------------------
  assign tx_valid = (state == ST_TX);
  assign tx_last  = (state == ST_TX) && (left == 3'h1);
  assign tx_data  = shift[39:32];

  always @(posedge mclk)
  begin
    if (srst)
    begin
      state <= ST_RX;
      cnt   <= 3'h0;
      b0    <= 8'h00;
      b1    <= 8'h00;
      b2    <= 8'h00;
      b3    <= 8'h00;
      b4    <= 8'h00;
      b5    <= 8'h00;
      shift <= 40'h0000000000;
      left  <= 3'h0;
      misc_settings             <= `MCC_RST_MISC;
      cold_junction_comp_offset <= `MCC_RST_OFS;
      cold_junction_comp_enable <= `MCC_RST_EN;
    end
    else
    begin
      case (state)
        ST_RX:
        begin
          if (rx_valid)
          begin
            // saturates at 7 so overlong frames still count as wrong length
            if (cnt != 3'h7)
              cnt <= cnt + 3'h1;
            case (cnt)
              3'h0: b0 <= rx_data;
              3'h1: b1 <= rx_data;
              3'h2: b2 <= rx_data;
              3'h3: b3 <= rx_data;
              3'h4: b4 <= rx_data;
              3'h5: b5 <= rx_data;
              default: b5 <= b5;
            endcase
          end
          if (rx_end)
            state <= ST_EVAL;
        end
        ST_EVAL:
        begin
          cnt <= 3'h0;
          if (take)
          begin
            shift <= rbuf;
            left  <= rlen;
            state <= ST_TX;
            if (ev[`MCC_IRQ_MISC])
              misc_settings <= b3;
            if (ev[`MCC_IRQ_OFS])
              cold_junction_comp_offset <= ofs_in;
            if (ev[`MCC_IRQ_EN])
              cold_junction_comp_enable <= b4[0];
          end
          else
            state <= ST_RX;
        end
        ST_TX:
        begin
          // bytes arriving while the reply drains are dropped
          if (tx_ready)
          begin
            shift <= {shift[31:0], 8'h00};
            left  <= left - 3'h1;
            if (left == 3'h1)
              state <= ST_RX;
          end
        end
        default:
        begin
          state <= ST_RX;
        end
      endcase
    end
  end

  // ----------------------------------------
  // settings outputs
  // ----------------------------------------
  // built from next values so the pins move on the same edge as the stored byte
  wire       misc_wr         = (state == ST_EVAL) && take && ev[`MCC_IRQ_MISC];
  wire       caps_wr         = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
                               (wb_adr_i == `MCC_REG_CTRL) && wb_sel_i[1];
  wire [7:0] next_misc       = misc_wr ? b3 : misc_settings;
  wire       next_cap_filter = caps_wr ? wb_dat_i[`MCC_CTRL_FILT] : cap_filter;
  wire       next_cap_fast   = caps_wr ? wb_dat_i[`MCC_CTRL_FAST] : cap_fast;
  reg        notch_50hz;
  reg        fast_conv;

  always @(posedge mclk)
  begin
    if (srst)
    begin
      notch_50hz <= 1'b0;
      fast_conv  <= 1'b0;
    end
    else
    begin
      notch_50hz <= next_cap_filter & next_misc[`MCC_BIT_FILTER];
      fast_conv  <= next_cap_fast & next_misc[`MCC_BIT_FAST];
    end
  end

  assign filter_50hz = notch_50hz;
  assign fast_mode   = fast_conv;

  // ----------------------------------------
  // wishbone slave and interrupts
  // ----------------------------------------
  wire       wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire       wb_wr  = wb_req && wb_we_i;
  wire [3:0] ev_set = (state == ST_EVAL && take) ? ev : 4'h0;
  reg  [3:0] next_irq_stat;

  always @*
  begin
    next_irq_stat = irq_stat;
    if (wb_wr && wb_adr_i == `MCC_REG_IRQ_STAT && wb_sel_i[0])
      next_irq_stat = irq_stat & ~wb_dat_i[3:0];
    // a new event beats a clear in the same cycle
    next_irq_stat = next_irq_stat | ev_set;
  end

  assign irq = |(irq_stat & irq_mask);

  always @(posedge mclk)
  begin
    if (srst)
    begin
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h00000000;
      own_addr   <= `MCC_RST_ADDR;
      cap_filter <= 1'b1;
      cap_fast   <= 1'b1;
      cap_tc     <= 1'b1;
      irq_stat   <= 4'h0;
      irq_mask   <= 4'h0;
    end
    else
    begin
      wb_ack_o <= wb_req;
      irq_stat <= next_irq_stat;
      if (wb_wr && wb_adr_i == `MCC_REG_CTRL)
      begin
        if (wb_sel_i[0])
          own_addr <= wb_dat_i[7:0];
        if (wb_sel_i[1])
        begin
          cap_filter <= wb_dat_i[`MCC_CTRL_FILT];
          cap_fast   <= wb_dat_i[`MCC_CTRL_FAST];
          cap_tc     <= wb_dat_i[`MCC_CTRL_TC];
        end
      end
      if (wb_wr && wb_adr_i == `MCC_REG_IRQ_MASK && wb_sel_i[0])
        irq_mask <= wb_dat_i[3:0];
      if (wb_req && !wb_we_i)
      begin
        case (wb_adr_i)
          `MCC_REG_CTRL:
            wb_dat_o <= {21'h000000, cap_tc, cap_fast, cap_filter, own_addr};
          `MCC_REG_STATE:
            wb_dat_o <= {cold_junction_comp_offset, 7'h00, cold_junction_comp_enable,
                         misc_settings};
          `MCC_REG_IRQ_STAT:
            wb_dat_o <= {28'h0000000, irq_stat};
          `MCC_REG_IRQ_MASK:
            wb_dat_o <= {28'h0000000, irq_mask};
          default:
            wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // mcc_cmd

// file: hdl/mcc_defs.vh
// constants for the misc and cold junction compensation command block
`ifndef MCC_DEFS_VH
`define MCC_DEFS_VH
// ----------------------------------------
// protocol bytes
// ----------------------------------------
`define MCC_FN_USER      8'h46
`define MCC_FN_EXCEPT    8'hC6
`define MCC_EXC_CODE     8'h03
`define MCC_SUB_MISC_WR  8'h2A
`define MCC_SUB_OFS_RD   8'h2B
`define MCC_SUB_OFS_WR   8'h2C
`define MCC_SUB_EN_RD    8'h2D
`define MCC_SUB_EN_WR    8'h2E
`define MCC_ADDR_MIN     8'h01
`define MCC_ADDR_MAX     8'hF7
`define MCC_STATUS_OK    8'h00
`define MCC_OFS_MAX      16'h1000
`define MCC_OFS_MIN      16'hF000
`define MCC_RES_FIXED    8'h5F
`define MCC_BIT_FILTER   7
`define MCC_BIT_FAST     5
`define MCC_LEN_MISC_WR  3'h4
`define MCC_LEN_OFS_RD   3'h4
`define MCC_LEN_OFS_WR   3'h6
`define MCC_LEN_EN_RD    3'h4
`define MCC_LEN_EN_WR    3'h5
`define MCC_LEN_EXC      3'h3
// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define MCC_REG_CTRL     4'h0
`define MCC_REG_STATE    4'h4
`define MCC_REG_IRQ_STAT 4'h8
`define MCC_REG_IRQ_MASK 4'hC
`define MCC_CTRL_FILT    8
`define MCC_CTRL_FAST    9
`define MCC_CTRL_TC      10
`define MCC_IRQ_MISC     0
`define MCC_IRQ_OFS      1
`define MCC_IRQ_EN       2
`define MCC_IRQ_EXC      3
// ----------------------------------------
// reset values
// ----------------------------------------
`define MCC_RST_ADDR     8'h01
`define MCC_RST_CTRL_CAP 3'h7
`define MCC_RST_MISC     8'h00
`define MCC_RST_OFS      16'h0000
`define MCC_RST_EN       1'h0
`endif

// file: tb/mcc_host.sv
// host side model: takes reply bytes, optionally stalling
module mcc_host
(
  input  wire       mclk,
  input  wire [7:0] tx_data,
  input  wire       tx_valid,
  input  wire       tx_last,
  input  wire       slow,
  output logic      tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rep[$];
  int         done = 0;
  initial tx_ready = 1'b0;
  // random stalls show whether reply bytes hold steady
  always @(posedge mclk)
  begin
    tx_ready <= slow ? 1'($urandom) : 1'b1;
    if (tx_valid && tx_ready)
    begin
      rep.push_back(tx_data);
      done <= done + (tx_last ? 1 : 0);
    end
  end
endmodule // mcc_host

// file: tb/mcc_cmd_checker.sv
// port assertions for the command block
module mcc_cmd_checker
(
  input wire        mclk,
  input wire        srst,
  input wire [7:0]  tx_data,
  input wire        tx_valid,
  input wire        tx_last,
  input wire        tx_ready,
  input wire [7:0]  misc_settings,
  input wire        filter_50hz,
  input wire        fast_mode,
  input wire [15:0] cold_junction_comp_offset,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  logic [2:0] idx;
  logic       exc;
  wire        take = tx_valid && tx_ready;
  // byte index within the reply in flight
  always @(posedge mclk)
    if (srst || (take && tx_last))
      idx <= 3'h0;
    else if (take)
      idx <= idx + 3'h1;
  always @(posedge mclk)
    if (take && idx == 3'h1)
      exc <= (tx_data == 8'hC6);
  sequence s_stall; tx_valid && !tx_ready; endsequence
  sequence s_wb_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  a_tx_hold: assert property (s_stall |=> tx_valid && $stable(tx_data))
    else $error("reply byte moved in stall");
  a_fn_byte: assert property (tx_valid && idx == 3'h1 |-> tx_data == 8'h46 || tx_data == 8'hC6)
    else $error("bad function byte");
  a_exc_code: assert property (tx_valid && idx == 3'h2 && exc |-> tx_data == 8'h03 && tx_last)
    else $error("bad exception reply");
  a_reply_len: assert property (tx_valid && tx_last |-> idx >= 3'h2 && idx <= 3'h4)
    else $error("bad reply length");
  a_misc_rsvd: assert property (misc_settings[6] == 1'b0 && misc_settings[4:0] == 5'h00)
    else $error("reserved bits stored");
  a_filter_bit: assert property (filter_50hz |-> misc_settings[7])
    else $error("filter without bit");
  a_fast_bit: assert property (fast_mode |-> misc_settings[5])
    else $error("fast without bit");
  a_ofs_range: assert property ($signed(cold_junction_comp_offset) <= 16'sh1000 &&
    $signed(cold_junction_comp_offset) >= 16'shF000) else $error("offset out of range");
  a_ack_next: assert property (s_wb_req |=> wb_ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
endmodule // mcc_cmd_checker
bind mcc_cmd mcc_cmd_checker i_mcc_cmd_checker (.mclk(mclk), .srst(srst), .tx_data(tx_data),
  .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready), .misc_settings(misc_settings),
  .filter_50hz(filter_50hz), .fast_mode(fast_mode), .cold_junction_comp_offset(cold_junction_comp_offset),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

// file: tb/mcc_cmd_tb.sv
// self-checking bench for the misc and compensation command block
module mcc_cmd_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] mcc_bq_t[$];
  logic        mclk = 1'b0, srst = 1'b1, slow = 1'b0, en, irq, filter_50hz, fast_mode;
  logic        rx_valid = 1'b0, rx_end = 1'b0, tx_valid, tx_last, tx_ready;
  logic        wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o;
  logic [7:0]  rx_data = 8'h00, tx_data, misc_settings, m_misc = 8'h00;
  logic [15:0] ofs, m_ofs = 16'h0000;
  logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic        m_en = 1'b0, m_tc = 1'b1, m_filt = 1'b1, m_fast = 1'b1;
  int          fails = 0, compares = 0, k;
  initial forever #4 mclk = ~mclk;
  mcc_cmd i_mcc_cmd (.mclk(mclk), .srst(srst), .rx_data(rx_data), .rx_valid(rx_valid), .rx_end(rx_end),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
    .misc_settings(misc_settings), .filter_50hz(filter_50hz), .fast_mode(fast_mode),
    .cold_junction_comp_offset(ofs), .cold_junction_comp_enable(en), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .irq(irq));
  mcc_host i_host (.mclk(mclk), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
    .slow(slow), .tx_ready(tx_ready));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic summarize;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (n = 0; n < 20; n++)
    begin
      @(posedge mclk);
      if (wb_ack_o === 1'b1)
        break;
    end
    if (n == 20)
    begin
      fails++;
      $display("unexpected at %0t: no bus ack", $time);
      summarize();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge mclk);
  endtask
  // reply the host should see, model state updated alongside
  function automatic mcc_bq_t expect_of(input mcc_bq_t f);
    mcc_bq_t ok;
    logic [7:0] s;
    logic [15:0] v;
    int n;
    n = f.size();
    s = f[2];
    v = (n > 5) ? {f[4], f[5]} : 16'h0000;
    ok = {f[0], 8'h46, s, 8'h00};
    if (f[0] != 8'h01 || (s > 8'h2A && s < 8'h2F && !m_tc) || s < 8'h2A || s > 8'h2E)
      return {};
    if (s == 8'h2A && n == 4 && (f[3] & {~m_filt, 1'b1, ~m_fast, 5'h1F}) == 8'h00)
      m_misc = f[3];
    else if (s == 8'h2B && n == 4 && f[3] == 8'h00)
      ok = {f[0], 8'h46, s, m_ofs[15:8], m_ofs[7:0]};
    else if (s == 8'h2C && n == 6 && f[3] == 8'h00 && $signed(v) <= 4096 && $signed(v) >= -4096)
      m_ofs = v;
    else if (s == 8'h2D && n == 4)
      ok[3] = {7'h00, m_en};
    else if (s == 8'h2E && n == 5 && f[3] == 8'h00 && f[4] < 8'h02)
      m_en = f[4][0];
    else
      return {f[0], 8'hC6, 8'h03};
    return ok;
  endfunction
  task automatic run(input logic [7:0] a, input logic [7:0] s, input logic [23:0] t, input int n);
    mcc_bq_t f, e;
    int i, d;
    f = {a, 8'h46, s};
    for (i = 0; i < n; i++)
      f.push_back(t[23 - 8 * i -: 8]);
    e = expect_of(f);
    d = i_host.done;
    i_host.rep.delete();
    foreach (f[j])
    begin
      rx_data <= f[j];
      rx_valid <= 1'b1;
      rx_end <= (j == f.size() - 1);
      @(posedge mclk);
    end
    rx_valid <= 1'b0;
    rx_end <= 1'b0;
    for (i = 0; i < 40 && i_host.done == d; i++)
      @(posedge mclk);
    if (e.size() > 0 && i == 40)
    begin
      fails++;
      $display("unexpected at %0t: no reply", $time);
      summarize();
    end
    check(i_host.rep.size(), e.size());
    foreach (e[j])
      check(i_host.rep[j], e[j]);
    check({misc_settings, ofs, en, filter_50hz, fast_mode},
          {m_misc, m_ofs, m_en, m_filt & m_misc[7], m_fast & m_misc[5]});
  endtask
  initial
  begin
    void'($urandom(32'hab0a2b92));
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    wb(1'b0, 4'h0, 32'h0);
    check(rd, 32'h0000_0701);
    run(8'h01, 8'h2A, 24'hA00000, 1);
    run(8'h01, 8'h2A, 24'h400000, 1);
    run(8'h01, 8'h2A, 24'h0, 0);
    run(8'h01, 8'h2C, 24'h001000, 3);
    run(8'h01, 8'h2B, 24'h0, 1);
    run(8'h01, 8'h2C, 24'h001001, 3);
    run(8'h01, 8'h2C, 24'h00F000, 3);
    run(8'h01, 8'h2C, 24'h00EFFF, 3);
    run(8'h01, 8'h2B, 24'h010000, 1);
    run(8'h01, 8'h2E, 24'h000100, 2);
    run(8'h01, 8'h2E, 24'h000200, 2);
    run(8'h01, 8'h2D, 24'h0, 1);
    run(8'h01, 8'h2D, 24'h0, 2);
    run(8'hF8, 8'h2D, 24'h0, 1);
    check(irq, 1'b0);
    wb(1'b1, 4'hC, 32'hF);
    check(irq, 1'b1);
    wb(1'b0, 4'h8, 32'h0);
    check(rd, 32'hF);
    wb(1'b1, 4'h8, 32'hF);
    check(irq, 1'b0);
    wb(1'b0, 4'h2, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, 4'h0, 32'h0000_0001);
    m_tc = 1'b0;
    m_filt = 1'b0;
    m_fast = 1'b0;
    wb(1'b0, 4'h0, 32'h0);
    check(rd, 32'h0000_0001);
    run(8'h01, 8'h2A, 24'h800000, 1);
    run(8'h01, 8'h2A, 24'h200000, 1);
    run(8'h01, 8'h2B, 24'h0, 1);
    wb(1'b1, 4'h0, 32'h0000_0701);
    m_tc = 1'b1;
    m_filt = 1'b1;
    m_fast = 1'b1;
    slow <= 1'b1;
    // zero tails half the time so that valid frames turn up often
    for (k = 0; k < 40; k++)
      run(($urandom % 8 == 0) ? 8'h00 : 8'h01, 8'h2A + 8'($urandom % 5),
          ($urandom % 2) ? 24'h0 : 24'($urandom), $urandom % 4);
    wb(1'b0, 4'h4, 32'h0);
    check(rd, {m_ofs, 7'h00, m_en, m_misc});
    // second reset in mid-run: settings and interrupt state return to idle
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    {m_misc, m_ofs, m_en} = 25'h0;
    wb(1'b0, 4'h4, 32'h0);
    check(rd, 32'h0);
    check({irq, filter_50hz, fast_mode, tx_valid}, 4'h0);
    wb(1'b0, 4'h0, 32'h0);
    check(rd, 32'h0000_0701);
    run(8'h01, 8'h2D, 24'h0, 1);
    summarize();
  end
endmodule // mcc_cmd_tb
